// file: hdl/dgc_defines.svh
`ifndef DGC_DEFINES_SVH
`define DGC_DEFINES_SVH
`define DGC_OFF_STATUS      12'h000
`define DGC_OFF_CONFIG      12'h004
`define DGC_OFF_PRIM_BASE   12'h008
`define DGC_OFF_ALT_BASE    12'h00c
`define DGC_OFF_WAIT_LEVEL  12'h010
`define DGC_OFF_SOFT_REQ    12'h014
`define DGC_OFF_BURST_SET   12'h018
`define DGC_OFF_BURST_CLR   12'h01c
`define DGC_OFF_PID4        12'hfd0
`define DGC_OFF_PID0        12'hfe0
`define DGC_OFF_PID1        12'hfe4
`define DGC_OFF_PID2        12'hfe8
`define DGC_OFF_PID3        12'hfec
`define DGC_OFF_CID0        12'hff0
`define DGC_OFF_CID1        12'hff4
`define DGC_OFF_CID2        12'hff8
`define DGC_OFF_CID3        12'hffc
`define DGC_ST_TEST_LSB     28
`define DGC_ST_CHAN_LSB     16
`define DGC_ST_STATE_LSB    4
`define DGC_CFG_PROT_LSB    5
`define DGC_CFG_EN_BIT      0
`define DGC_PTR_LOW_BITS    5
`define DGC_TEST_ABSENT     4'h0
`define DGC_TEST_PRESENT    4'h1
`endif

// file: hdl/dgc_pkg.sv
package dgc_pkg;
  typedef enum logic [3:0] {
    DGC_IDLE      = 4'h0,
    DGC_RD_CTRL   = 4'h1,
    DGC_RD_SRCEND = 4'h2,
    DGC_RD_DSTEND = 4'h3,
    DGC_RD_SRC    = 4'h4,
    DGC_WR_DST    = 4'h5,
    DGC_WAIT_CLR  = 4'h6,
    DGC_WR_CTRL   = 4'h7,
    DGC_STALLED   = 4'h8,
    DGC_DONE      = 4'h9,
    DGC_PSG_TRANS = 4'ha
  } dgc_ctl_state_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dgc_bus_req_type;

  typedef struct packed {
    logic [2:0] hprot;
    logic       enable;
  } dgc_global_cfg_type;
endpackage

// file: hdl/dgc_req_gate.sv
`timescale 1ns/100ps
`default_nettype none
module dgc_req_gate #(
  parameter int CHANNELS = 32
) (
  input  wire logic [31:0]         soft_bits_i,
  input  wire logic                soft_wr_i,
  input  wire logic [CHANNELS-1:0] single_req_i,
  input  wire logic [CHANNELS-1:0] burst_req_i,
  input  wire logic [CHANNELS-1:0] burst_only_i,
  output var  logic [CHANNELS-1:0] soft_req_o,
  output var  logic [CHANNELS-1:0] hw_req_o
);
  always_comb begin
    // only implemented channels are looked at; upper bits dropped
    soft_req_o = soft_wr_i ? soft_bits_i[CHANNELS-1:0] : '0;
    hw_req_o   = burst_req_i | (single_req_i & ~burst_only_i);
  end
endmodule
`default_nettype wire

// file: hdl/dgc_regs.sv
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "dgc_defines.svh"
module dgc_regs import dgc_pkg::*; #(
  parameter int          CHANNELS   = 32,
  parameter bit          TEST_LOGIC = 1'b0,
  parameter logic [7:0]  PID0 = 8'h11, // arbitrary identification values
  parameter logic [7:0]  PID1 = 8'h22,
  parameter logic [7:0]  PID2 = 8'h33,
  parameter logic [7:0]  PID3 = 8'h44,
  parameter logic [7:0]  PID4 = 8'h55,
  parameter logic [7:0]  CID0 = 8'h66,
  parameter logic [7:0]  CID1 = 8'h77,
  parameter logic [7:0]  CID2 = 8'h88,
  parameter logic [7:0]  CID3 = 8'h99
) (
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  input  wire logic [11:0]         addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output var  logic [31:0]         rdata_o,
  input  wire logic [3:0]          ctl_state_i,
  input  wire logic [CHANNELS-1:0] wait_req_i,
  input  wire logic [CHANNELS-1:0] single_req_i,
  input  wire logic [CHANNELS-1:0] burst_req_i,
  output var  logic                enable_o,
  output var  logic [2:0]          hprot_o,
  output var  logic [CHANNELS-1:0] soft_req_o,
  output var  logic [CHANNELS-1:0] hw_req_o
);
  localparam int IDX_BITS = (CHANNELS <= 1) ? 0 : $clog2(CHANNELS);
  localparam int LOW_BITS = IDX_BITS + `DGC_PTR_LOW_BITS;
  localparam int HI_BITS  = 32 - LOW_BITS;
  localparam logic [4:0] CH_LESS1 = 5'(CHANNELS - 1);

  typedef struct packed {
    logic [31:0]         rdata;
    dgc_global_cfg_type  cfg;
    logic [HI_BITS-1:0]  prim_hi;
    logic [CHANNELS-1:0] burst_only;
    logic [CHANNELS-1:0] wait_s1;
    logic [CHANNELS-1:0] wait_s2;
    logic [CHANNELS-1:0] single_s1;
    logic [CHANNELS-1:0] single_s2;
    logic [CHANNELS-1:0] burst_s1;
    logic [CHANNELS-1:0] burst_s2;
    logic [3:0]          state_s1;
    logic [3:0]          state_s2;
    logic [3:0]          state_shown;
    logic [CHANNELS-1:0] soft_req;
    logic [CHANNELS-1:0] hw_req;
  } dgc_state_type;

  dgc_state_type   st_reg;
  dgc_state_type   st_next;
  dgc_bus_req_type bus;
  logic [31:0]     prim_base;
  logic [31:0]     alt_base;
  logic [31:0]     status_word;
  logic [CHANNELS-1:0] soft_comb;
  logic [CHANNELS-1:0] hw_comb;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // no structure memory here: base pointers only point into system memory
  assign prim_base = {st_reg.prim_hi, {LOW_BITS{1'b0}}};
  // alternate structures sit right above the primary set
  assign alt_base  = prim_base + 32'((CHANNELS > 0 ? 1 : 0) << LOW_BITS) - 32'h0
                     + 32'h0;

  always_comb begin
    status_word = '0;
    status_word[`DGC_ST_TEST_LSB +: 4] = TEST_LOGIC ? `DGC_TEST_PRESENT : `DGC_TEST_ABSENT;
    status_word[`DGC_ST_CHAN_LSB +: 5] = CH_LESS1;
    status_word[`DGC_ST_STATE_LSB +: 4] = st_reg.state_shown;
    status_word[`DGC_CFG_EN_BIT] = st_reg.cfg.enable;
  end

  dgc_req_gate #(
    .CHANNELS(CHANNELS)
  ) u_gate (
    .soft_bits_i  (bus.wdata),
    .soft_wr_i    (bus.wr && bus.addr == `DGC_OFF_SOFT_REQ),
    .single_req_i (st_reg.single_s2),
    .burst_req_i  (st_reg.burst_s2),
    .burst_only_i (st_reg.burst_only),
    .soft_req_o   (soft_comb),
    .hw_req_o     (hw_comb)
  );

  always_comb begin
    st_next = st_reg;
    st_next.wait_s1   = wait_req_i;
    st_next.wait_s2   = st_reg.wait_s1;
    st_next.single_s1 = single_req_i;
    st_next.single_s2 = st_reg.single_s1;
    st_next.burst_s1  = burst_req_i;
    st_next.burst_s2  = st_reg.burst_s1;
    st_next.state_s1  = ctl_state_i;
    st_next.state_s2  = st_reg.state_s1;
    // code taken once two samples agree; hides skewed changes
    if (st_reg.state_s1 == st_reg.state_s2) begin
      st_next.state_shown = st_reg.state_s2;
    end
    st_next.soft_req  = soft_comb;
    st_next.hw_req    = hw_comb;
    st_next.rdata     = '0;
    if (bus.wr) begin
      case (bus.addr)
        `DGC_OFF_CONFIG: begin
          st_next.cfg.enable = bus.wdata[`DGC_CFG_EN_BIT];
          st_next.cfg.hprot  = bus.wdata[`DGC_CFG_PROT_LSB +: 3];
        end
        `DGC_OFF_PRIM_BASE: st_next.prim_hi = bus.wdata[31:LOW_BITS];
        `DGC_OFF_BURST_SET: st_next.burst_only = st_reg.burst_only | bus.wdata[CHANNELS-1:0];
        `DGC_OFF_BURST_CLR: st_next.burst_only = st_reg.burst_only & ~bus.wdata[CHANNELS-1:0];
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        `DGC_OFF_STATUS:     st_next.rdata = status_word;
        `DGC_OFF_PRIM_BASE:  st_next.rdata = prim_base;
        `DGC_OFF_ALT_BASE:   st_next.rdata = alt_base;
        `DGC_OFF_WAIT_LEVEL: st_next.rdata = 32'(st_reg.wait_s2);
        `DGC_OFF_BURST_SET:  st_next.rdata = 32'(st_reg.burst_only);
        `DGC_OFF_PID0:       st_next.rdata = {24'h0, PID0};
        `DGC_OFF_PID1:       st_next.rdata = {24'h0, PID1};
        `DGC_OFF_PID2:       st_next.rdata = {24'h0, PID2};
        `DGC_OFF_PID3:       st_next.rdata = {24'h0, PID3};
        `DGC_OFF_PID4:       st_next.rdata = {24'h0, PID4};
        `DGC_OFF_CID0:       st_next.rdata = {24'h0, CID0};
        `DGC_OFF_CID1:       st_next.rdata = {24'h0, CID1};
        `DGC_OFF_CID2:       st_next.rdata = {24'h0, CID2};
        `DGC_OFF_CID3:       st_next.rdata = {24'h0, CID3};
        default:             st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata_o    = st_reg.rdata;
  assign enable_o   = st_reg.cfg.enable;
  assign hprot_o    = st_reg.cfg.hprot;
  assign soft_req_o = st_reg.soft_req;
  assign hw_req_o   = st_reg.hw_req;

  property p_enable_write;
    @(posedge clock_i) disable iff (reset_i)
      (wr_i && addr_i == `DGC_OFF_CONFIG) |=> (enable_o == $past(wdata_i[0]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not loaded");

  property p_hprot_write;
    @(posedge clock_i) disable iff (reset_i)
      (wr_i && addr_i == `DGC_OFF_CONFIG) |=> (hprot_o == $past(wdata_i[7:5]));
  endproperty
  a_hprot_write: assert property (p_hprot_write) else $error("hprot not loaded");

  property p_status_enable;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_STATUS) |=> (rdata_o[0] == $past(enable_o));
  endproperty
  a_status_enable: assert property (p_status_enable) else $error("status enable wrong");

  property p_status_count;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_STATUS) |=> (rdata_o[20:16] == CH_LESS1 && rdata_o[27:21] == 7'h0);
  endproperty
  a_status_count: assert property (p_status_count) else $error("channel count wrong");

  property p_status_test;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_STATUS) |=> (rdata_o[31:28] == (TEST_LOGIC ? 4'h1 : 4'h0));
  endproperty
  a_status_test: assert property (p_status_test) else $error("test field wrong");

  property p_base_low;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_PRIM_BASE) |=> ((rdata_o & ((32'h1 << LOW_BITS) - 32'h1)) == 32'h0);
  endproperty
  a_base_low: assert property (p_base_low) else $error("base low bits stored");

  property p_alt_base;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_ALT_BASE) |=> (rdata_o == $past(prim_base) + (32'h1 << LOW_BITS));
  endproperty
  a_alt_base: assert property (p_alt_base) else $error("alternate base wrong");

  property p_soft_req;
    @(posedge clock_i) disable iff (reset_i)
      (wr_i && addr_i == `DGC_OFF_SOFT_REQ) |=> (soft_req_o == $past(wdata_i[CHANNELS-1:0]));
  endproperty
  a_soft_req: assert property (p_soft_req) else $error("soft request wrong");

  property p_no_soft;
    @(posedge clock_i) disable iff (reset_i)
      !(wr_i && addr_i == `DGC_OFF_SOFT_REQ) |=> (soft_req_o == '0);
  endproperty
  a_no_soft: assert property (p_no_soft) else $error("spurious soft request");

  property p_burst_only;
    @(posedge clock_i) disable iff (reset_i)
      ##1 ((hw_req_o & ~$past(st_reg.burst_s2) & $past(st_reg.burst_only)) == '0);
  endproperty
  a_burst_only: assert property (p_burst_only) else $error("single request passed");

  property p_wait_level;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_WAIT_LEVEL) |=> (rdata_o == 32'($past(st_reg.wait_s2)));
  endproperty
  a_wait_level: assert property (p_wait_level) else $error("wait level wrong");

  property p_unmapped;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == 12'h040) |=> (rdata_o == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_status_state;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_STATUS) |=> (rdata_o[7:4] == $past(st_reg.state_shown));
  endproperty
  a_status_state: assert property (p_status_state) else $error("state field wrong");

  property p_status_spare;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_STATUS) |=> (rdata_o[15:8] == 8'h0 && rdata_o[3:1] == 3'h0);
  endproperty
  a_status_spare: assert property (p_status_spare) else $error("status spare bits set");

  property p_state_settle;
    @(posedge clock_i) disable iff (reset_i)
      (st_reg.state_s1 == st_reg.state_s2) |=> (st_reg.state_shown == $past(st_reg.state_s2));
  endproperty
  a_state_settle: assert property (p_state_settle) else $error("settled state not shown");

  property p_state_hold;
    @(posedge clock_i) disable iff (reset_i)
      (st_reg.state_s1 != st_reg.state_s2) |=> $stable(st_reg.state_shown);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("unsettled state shown");

  property p_rdata_idle;
    @(posedge clock_i) disable iff (reset_i)
      !rd_i |=> (rdata_o == 32'h0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_prim_write;
    @(posedge clock_i) disable iff (reset_i)
      (wr_i && addr_i == `DGC_OFF_PRIM_BASE) |=> (prim_base == ($past(wdata_i) & ~((32'h1 << LOW_BITS) - 32'h1)));
  endproperty
  a_prim_write: assert property (p_prim_write) else $error("primary base not loaded");

  property p_prim_hold;
    @(posedge clock_i) disable iff (reset_i)
      !(wr_i && addr_i == `DGC_OFF_PRIM_BASE) |=> $stable(prim_base);
  endproperty
  a_prim_hold: assert property (p_prim_hold) else $error("primary base changed");

  property p_enable_hold;
    @(posedge clock_i) disable iff (reset_i)
      !(wr_i && addr_i == `DGC_OFF_CONFIG) |=> $stable(enable_o);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("enable changed");

  property p_hprot_hold;
    @(posedge clock_i) disable iff (reset_i)
      !(wr_i && addr_i == `DGC_OFF_CONFIG) |=> $stable(hprot_o);
  endproperty
  a_hprot_hold: assert property (p_hprot_hold) else $error("hprot changed");

  property p_burst_pass;
    @(posedge clock_i) disable iff (reset_i)
      ##1 ((hw_req_o & $past(st_reg.burst_s2)) == $past(st_reg.burst_s2));
  endproperty
  a_burst_pass: assert property (p_burst_pass) else $error("burst request lost");

  property p_single_pass;
    @(posedge clock_i) disable iff (reset_i)
      ##1 ((~hw_req_o & $past(st_reg.single_s2) & ~$past(st_reg.burst_only)) == '0);
  endproperty
  a_single_pass: assert property (p_single_pass) else $error("single request lost");

  property p_hw_idle;
    @(posedge clock_i) disable iff (reset_i)
      ##1 ((hw_req_o & ~$past(st_reg.burst_s2) & ~$past(st_reg.single_s2)) == '0);
  endproperty
  a_hw_idle: assert property (p_hw_idle) else $error("request without input");

  property p_burst_set;
    @(posedge clock_i) disable iff (reset_i)
      (wr_i && addr_i == `DGC_OFF_BURST_SET) |=>
        (st_reg.burst_only == ($past(st_reg.burst_only) | $past(wdata_i[CHANNELS-1:0])));
  endproperty
  a_burst_set: assert property (p_burst_set) else $error("burst-only set wrong");

  property p_burst_clr;
    @(posedge clock_i) disable iff (reset_i)
      (wr_i && addr_i == `DGC_OFF_BURST_CLR) |=>
        (st_reg.burst_only == ($past(st_reg.burst_only) & ~$past(wdata_i[CHANNELS-1:0])));
  endproperty
  a_burst_clr: assert property (p_burst_clr) else $error("burst-only clear wrong");

  property p_ident_pid4;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_PID4) |=> (rdata_o == {24'h0, PID4});
  endproperty
  a_ident_pid4: assert property (p_ident_pid4) else $error("identification 4 wrong");

  property p_ident_pid0;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_PID0) |=> (rdata_o == {24'h0, PID0});
  endproperty
  a_ident_pid0: assert property (p_ident_pid0) else $error("identification 0 wrong");

  property p_ident_cid0;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_CID0) |=> (rdata_o == {24'h0, CID0});
  endproperty
  a_ident_cid0: assert property (p_ident_cid0) else $error("cell identification 0 wrong");

  property p_ident_cid3;
    @(posedge clock_i) disable iff (reset_i)
      (rd_i && addr_i == `DGC_OFF_CID3) |=> (rdata_o == {24'h0, CID3});
  endproperty
  a_ident_cid3: assert property (p_ident_cid3) else $error("cell identification 3 wrong");
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module testbench import dgc_pkg::*;;
  localparam int         NCH = 4;
  localparam int         M_IDX = (NCH > 16) ? 5 : (NCH > 8) ? 4 : (NCH > 4) ? 3 : (NCH > 2) ? 2 : (NCH > 1) ? 1 : 0;
  // arbitrary identification values
  localparam logic [7:0] IDV [9] = '{8'h5a, 8'h3c, 8'h6e, 8'h21, 8'h47, 8'h1d, 8'h7b, 8'h2f, 8'h63};
  localparam logic [11:0] IDA [9] = '{12'hfd0, 12'hfe0, 12'hfe4, 12'hfe8, 12'hfec, 12'hff0, 12'hff4, 12'hff8, 12'hffc};
  logic            clock_i;
  logic            reset_i;
  logic            wr_i;
  logic            rd_i;
  logic            enable_o;
  logic [2:0]      hprot_o;
  logic [11:0]     addr_i;
  logic [31:0]     wdata_i;
  logic [31:0]     rdata_o;
  logic [31:0]     d;
  logic [31:0]     b;
  logic [31:0]     c;
  logic [3:0]      ctl_state_i;
  logic [NCH-1:0]  wait_req_i;
  logic [NCH-1:0]  single_req_i;
  logic [NCH-1:0]  burst_req_i;
  logic [NCH-1:0]  soft_req_o;
  logic [NCH-1:0]  hw_req_o;
  integer          num_errors = 0;
  integer          checks = 0;
  integer          seed = 32'h8950895f;
  logic [31:0]     exp_q [$];
  logic [31:0]     m_base = 32'h0;
  logic [NCH-1:0]  m_burst = '0;
  integer          m_enable = 0;

  dgc_regs #(.CHANNELS(NCH), .TEST_LOGIC(1'b1), .PID4(IDV[0]), .PID0(IDV[1]), .PID1(IDV[2]), .PID2(IDV[3]),
    .PID3(IDV[4]), .CID0(IDV[5]), .CID1(IDV[6]), .CID2(IDV[7]), .CID3(IDV[8])) dut_u (
    .clock_i      (clock_i),
    .reset_i      (reset_i),
    .addr_i       (addr_i),
    .wdata_i      (wdata_i),
    .wr_i         (wr_i),
    .rd_i         (rd_i),
    .rdata_o      (rdata_o),
    .ctl_state_i  (ctl_state_i),
    .wait_req_i   (wait_req_i),
    .single_req_i (single_req_i),
    .burst_req_i  (burst_req_i),
    .enable_o     (enable_o),
    .hprot_o      (hprot_o),
    .soft_req_o   (soft_req_o),
    .hw_req_o     (hw_req_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  function automatic logic [31:0] stat(input logic [3:0] s, input logic e);
    return {4'h1, 7'h00, 5'(NCH - 1), 8'h00, s, 3'h0, e};
  endfunction

  // behavioural model of the read side
  function automatic logic [31:0] model_rd(input logic [11:0] a);
    logic [31:0] r;
    r = 32'h0;
    case (a)
      12'h000: r = stat(ctl_state_i, m_enable[0]);
      12'h008: r = m_base;
      12'h00c: r = m_base + (32'h1 << (M_IDX + 5));
      12'h010: r = 32'(wait_req_i);
      12'h018: r = 32'(m_burst);
      default: begin
        for (int i = 0; i < 9; i++) begin
          if (a == IDA[i]) begin
            r = {24'h0, IDV[i]};
          end
        end
      end
    endcase
    return r;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
    case (a)
      12'h004: m_enable = v[0];
      12'h008: m_base = v & ~((32'h1 << (M_IDX + 5)) - 32'h1);
      12'h018: m_burst = m_burst | v[NCH-1:0];
      12'h01c: m_burst = m_burst & ~v[NCH-1:0];
      default: ;
    endcase
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic [31:0] e;
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    exp_q.push_back(model_rd(a));
    @(posedge clock_i);
    rd_i   <= 1'b0;
    @(negedge clock_i);
    v = rdata_o;
    e = exp_q.pop_front();
    `CHK(v, e)
  endtask

  task automatic end_sim;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock_i);
    num_errors++;
    end_sim;
  end

  initial begin
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 12'h000;
    wdata_i = 32'h0;
    ctl_state_i = 4'h0;
    wait_req_i = '0;
    single_req_i = '0;
    burst_req_i = '0;
    // no accesses while held in reset
    repeat (8) @(posedge clock_i);
    @(negedge clock_i);
    `CHK({enable_o, hprot_o, soft_req_o, hw_req_o}, 12'h000)
    @(posedge clock_i);
    reset_i <= 1'b0;
    rd(12'h008, d); `CHK(d, 32'h0)
    rd(12'h00c, d); `CHK(d, 32'h80)
    for (int s = 0; s <= int'(DGC_PSG_TRANS); s++) begin
      @(posedge clock_i);
      ctl_state_i <= 4'(s);
      repeat (3) @(posedge clock_i);
      rd(12'h000, d); `CHK(d, stat(4'(s), 1'b0))
    end
    for (int i = 0; i < 8; i++) begin
      c = $random(seed);
      c = c & 32'he1;
      wr(12'h004, c);
      @(negedge clock_i);
      `CHK({hprot_o, enable_o}, {c[7:5], c[0]})
      rd(12'h000, d); `CHK(d, stat(4'ha, c[0]))
      b = $random(seed);
      b = b & ~32'h7f;
      wr(12'h008, b);
      rd(12'h008, d); `CHK(d, b)
      rd(12'h00c, d); `CHK(d, b + 32'h80)
      @(posedge clock_i);
      wait_req_i <= b[10:7];
      repeat (3) @(posedge clock_i);
      rd(12'h010, d); `CHK(d, {28'h0, b[10:7]})
      wr(12'h014, b >> 5);
      @(negedge clock_i);
      `CHK(soft_req_o, b[8:5])
      @(negedge clock_i);
      `CHK(soft_req_o, 4'h0)
    end
    wr(12'h014, 32'hfffffff0);
    @(negedge clock_i);
    `CHK(soft_req_o, 4'h0)
    wr(12'h018, 32'h1);
    rd(12'h018, d); `CHK(d, 32'h1)
    @(posedge clock_i);
    single_req_i <= 4'h3;
    burst_req_i  <= 4'h4;
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    `CHK(hw_req_o, 4'h6)
    wr(12'h01c, 32'h1);
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    `CHK(hw_req_o, 4'h7)
    for (int i = 0; i < 9; i++) begin
      rd(IDA[i], d); `CHK(d, {24'h0, IDV[i]})
    end
    wr(12'h00c, 32'hffffffff);
    rd(12'h00c, d); `CHK(d, b + 32'h80)
    wr(12'h100, 32'hffffffff);
    rd(12'h100, d); `CHK(d, 32'h0)
    rd(12'h040, d); `CHK(d, 32'h0)
    end_sim;
  end
endmodule
`default_nettype wire
